// ===== hw/flt_consts.svh
`ifndef FLT_CONSTS_SVH
`define FLT_CONSTS_SVH

// ----------------------------------------
// monitor status codes
// ----------------------------------------
`define FLT_MON_UNDER    2'h0
`define FLT_MON_OVER     2'h1
`define FLT_MON_INVALID  2'h2
`define FLT_MON_GOOD     2'h3

// ----------------------------------------
// flash page flag
// ----------------------------------------
`define FLT_FLAG_OFFSET  8'h00
`define FLT_FLAG_EMPTY   8'hff
`define FLT_FLAG_WRITTEN 8'hc3

// ----------------------------------------
// limits and timing
// ----------------------------------------
`define FLT_RECORD_LIMIT 8'hfa
`define FLT_DUMP_PERIODS 4'hd
`define FLT_INIT_STEPS   2'h2

`endif

// ===== hw/flt_pkg.sv
package flt_pkg;

	typedef enum logic [6:0] {
		SEQ_INIT0  = 7'h01,
		SEQ_INIT1  = 7'h02,
		SEQ_PWRUP  = 7'h04,
		SEQ_NOP    = 7'h08,
		SEQ_WATCH  = 7'h10,
		SEQ_DUMP   = 7'h20,
		SEQ_REARM  = 7'h40
	} flt_seq_t;

	typedef enum logic [4:0] {
		SCAN_START = 5'h01,
		SCAN_REQ   = 5'h02,
		SCAN_WAIT  = 5'h04,
		SCAN_READY = 5'h08,
		SCAN_FULL  = 5'h10
	} flt_scan_t;

endpackage

// ===== hw/flt_mon_if.sv
`timescale 1ns/1ps

interface flt_mon_if;
	logic [1:0] status_a;
	logic [1:0] status_b;
	logic       both_good;
	logic       any_out;
	logic       both_low;

	modport decoder
	(
		input  status_a,
		input  status_b,
		output both_good,
		output any_out,
		output both_low
	);

	modport user
	(
		output status_a,
		output status_b,
		input  both_good,
		input  any_out,
		input  both_low
	);
endinterface

// ===== hw/flt_mon_decode.sv
`timescale 1ns/1ps
`include "flt_consts.svh"

module flt_mon_decode
(
	flt_mon_if.decoder mon
);

	// ----------------------------------------
	// window decode of both trigger monitors
	// ----------------------------------------
	// window mode: lower trip 1.5 V, upper 2.5 V, set in the analog section
	always_comb
	begin
		mon.both_good = (mon.status_a == `FLT_MON_GOOD) &&
			(mon.status_b == `FLT_MON_GOOD);
		// an invalid code also counts as outside the window
		mon.any_out = !mon.both_good;
		mon.both_low = (mon.status_a == `FLT_MON_UNDER) &&
			(mon.status_b == `FLT_MON_UNDER);
	end

endmodule

// ===== hw/flt_logger.sv
// Operation
// - first two sequencer steps make outputs safe, dump request held high.
// - wait for supplies to be normal before fault checking.
// - both monitors in window is healthy; either outside declares fault.
// - trigger monitors are window comparators with lower and upper trips.
// - after a declared fault the next step drives dump request low.
// - while dump request low, status is shifted out on three lines.
// - after dump wait for both monitors below lower trip, then restart.
// - monitor code 00 under, 11 good, 01 over, 10 invalid.
// - at start-up or reset read flag byte at offset zero of page.
// - page holding a fault advances page counter by one and rechecks.
// - scan until an empty page; next record goes there, others kept.
// - erase notice low resets page counter to page zero.
// - flag 0xff means empty page, 0xc3 means written record.
// - at most 250 records; then memory full and no more writes.
// - capture samples status lines on falling edge, 13 clock periods.
`timescale 1ns/1ps
`include "flt_consts.svh"

module flt_logger
(
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       clk_en_i,
	input  wire logic [1:0] trigger_monitor_a_i,
	input  wire logic [1:0] trigger_monitor_b_i,
	input  wire logic       supplies_ok_i,
	input  wire logic [2:0] dump_status_i,
	input  wire logic       log_erase_notice_n_i,
	input  wire logic       record_done_i,
	input  wire logic       flag_ack_i,
	input  wire logic [7:0] flag_data_i,
	output logic            outputs_safe_o,
	output logic            fault_record_trigger_n_o,
	output logic            status_line_0_o,
	output logic            status_line_1_o,
	output logic            status_line_2_o,
	output logic            flag_req_o,
	output logic [7:0]      flag_page_o,
	output logic [7:0]      flag_offset_o,
	output logic            page_ready_o,
	output logic            log_memory_full_o
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// monitor codes and erase notice come from outside this clock domain
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s1_d;
	logic [5:0] pin_s2_q;
	logic [5:0] pin_s2_d;

	always_comb
	begin
		pin_s1_d = {log_erase_notice_n_i, supplies_ok_i,
			trigger_monitor_b_i, trigger_monitor_a_i};
		pin_s2_d = pin_s1_q;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_s1_q <= 6'h20;
			pin_s2_q <= 6'h20;
		end
		else if (clk_en_i)
		begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	logic erase_n;
	logic sup_ok;
	assign erase_n = pin_s2_q[5];
	assign sup_ok  = pin_s2_q[4];

	flt_mon_if mon ();
	assign mon.status_a = pin_s2_q[1:0];
	assign mon.status_b = pin_s2_q[3:2];

	flt_mon_decode u_decode
	(
		.mon (mon)
	);

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	flt_pkg::flt_seq_t seq_q;
	flt_pkg::flt_seq_t seq_d;
	logic              trig_n_q;
	logic              trig_n_d;
	logic              safe_q;
	logic              safe_d;
	logic [3:0]        dump_cnt_q;
	logic [3:0]        dump_cnt_d;

	always_comb
	begin
		seq_d      = seq_q;
		trig_n_d   = trig_n_q;
		safe_d     = safe_q;
		dump_cnt_d = dump_cnt_q;
		case (seq_q)
			flt_pkg::SEQ_INIT0:
			begin
				safe_d   = 1'b1;
				trig_n_d = 1'b1;
				seq_d    = flt_pkg::SEQ_INIT1;
			end
			flt_pkg::SEQ_INIT1:
			begin
				safe_d   = 1'b1;
				trig_n_d = 1'b1;
				seq_d    = flt_pkg::SEQ_PWRUP;
			end
			flt_pkg::SEQ_PWRUP:
			begin
				// no checking while rails still ramp
				if (sup_ok)
				begin
					safe_d = 1'b0;
					seq_d  = flt_pkg::SEQ_NOP;
				end
			end
			flt_pkg::SEQ_NOP:
				seq_d = flt_pkg::SEQ_WATCH;
			flt_pkg::SEQ_WATCH:
			begin
				if (mon.any_out)
					seq_d = flt_pkg::SEQ_DUMP;
			end
			flt_pkg::SEQ_DUMP:
			begin
				trig_n_d   = 1'b0;
				dump_cnt_d = dump_cnt_q + 4'h1;
				// hold the request for the whole 13-period shift-out
				if (dump_cnt_q == `FLT_DUMP_PERIODS)
				begin
					trig_n_d   = 1'b1;
					dump_cnt_d = 4'h0;
					seq_d      = flt_pkg::SEQ_REARM;
				end
			end
			flt_pkg::SEQ_REARM:
			begin
				// one record per event: both must drop out first
				if (mon.both_low)
					seq_d = flt_pkg::SEQ_INIT0;
			end
			default:
			begin
				seq_d    = flt_pkg::SEQ_INIT0;
				trig_n_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			seq_q      <= flt_pkg::SEQ_INIT0;
			trig_n_q   <= 1'b1;
			safe_q     <= 1'b1;
			dump_cnt_q <= 4'h0;
		end
		else if (clk_en_i)
		begin
			seq_q      <= seq_d;
			trig_n_q   <= trig_n_d;
			safe_q     <= safe_d;
			dump_cnt_q <= dump_cnt_d;
		end
	end

	// ----------------------------------------
	// status serialiser
	// ----------------------------------------
	// the source lines are same-domain logic, so no synchroniser here
	logic [2:0] stat_q;
	logic [2:0] stat_d;

	always_comb
	begin
		stat_d = trig_n_q ? 3'h0 : dump_status_i;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			stat_q <= 3'h0;
		else if (clk_en_i)
			stat_q <= stat_d;
	end

	assign status_line_0_o          = stat_q[0];
	assign status_line_1_o          = stat_q[1];
	assign status_line_2_o          = stat_q[2];
	assign fault_record_trigger_n_o = trig_n_q;
	assign outputs_safe_o           = safe_q;

	// ----------------------------------------
	// page scan
	// ----------------------------------------
	flt_pkg::flt_scan_t scan_q;
	flt_pkg::flt_scan_t scan_d;
	logic [7:0]         page_q;
	logic [7:0]         page_d;
	logic               full_q;
	logic               full_d;

	always_comb
	begin
		scan_d = scan_q;
		page_d = page_q;
		full_d = full_q;
		case (scan_q)
			flt_pkg::SCAN_START:
				scan_d = flt_pkg::SCAN_REQ;
			flt_pkg::SCAN_REQ:
				scan_d = flt_pkg::SCAN_WAIT;
			flt_pkg::SCAN_WAIT:
			begin
				if (flag_ack_i)
				begin
					if (flag_data_i == `FLT_FLAG_EMPTY)
						scan_d = flt_pkg::SCAN_READY;
					else if (page_q == `FLT_RECORD_LIMIT - 8'h1)
					begin
						// no wrap: old records must survive
						full_d = 1'b1;
						scan_d = flt_pkg::SCAN_FULL;
					end
					else
					begin
						// 0xc3 or any non-empty byte is taken as used
						page_d = page_q + 8'h1;
						scan_d = flt_pkg::SCAN_REQ;
					end
				end
			end
			flt_pkg::SCAN_READY:
			begin
				if (record_done_i)
				begin
					if (page_q == `FLT_RECORD_LIMIT - 8'h1)
					begin
						full_d = 1'b1;
						scan_d = flt_pkg::SCAN_FULL;
					end
					else
						page_d = page_q + 8'h1;
				end
			end
			flt_pkg::SCAN_FULL:
				full_d = 1'b1;
			default:
				scan_d = flt_pkg::SCAN_START;
		endcase
		// erase notice overrides everything; controller pulses it on erase
		if (!erase_n)
		begin
			page_d = 8'h0;
			full_d = 1'b0;
			scan_d = flt_pkg::SCAN_READY;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			scan_q <= flt_pkg::SCAN_START;
			page_q <= 8'h0;
			full_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			scan_q <= scan_d;
			page_q <= page_d;
			full_q <= full_d;
		end
	end

	assign flag_req_o        = (scan_q == flt_pkg::SCAN_REQ);
	assign flag_page_o       = page_q;
	assign flag_offset_o     = `FLT_FLAG_OFFSET;
	assign page_ready_o      = (scan_q == flt_pkg::SCAN_READY);
	assign log_memory_full_o = full_q;

endmodule

// ===== testbench/flt_logger_sva.sv
`timescale 1ns/1ps
// ------------
// logger checker
// ------------
module flt_logger_chk
(
	input wire logic       ref_clk_i,
	input wire logic       rstn_i,
	input wire logic [1:0] trigger_monitor_a_i,
	input wire logic [1:0] trigger_monitor_b_i,
	input wire logic [2:0] dump_status_i,
	input wire logic       log_erase_notice_n_i,
	input wire logic       flag_ack_i,
	input wire logic [7:0] flag_data_i,
	input wire logic       outputs_safe_o,
	input wire logic       fault_record_trigger_n_o,
	input wire logic       status_line_0_o,
	input wire logic       status_line_1_o,
	input wire logic       status_line_2_o,
	input wire logic       flag_req_o,
	input wire logic [7:0] flag_page_o,
	input wire logic       page_ready_o,
	input wire logic       log_memory_full_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [4:0] low_q;
	logic [4:0] low_d;
	logic [2:0] lines;
	assign lines = {status_line_2_o, status_line_1_o, status_line_0_o};
	// wraps if stuck low; the length check then fails anyway
	always_comb
		low_d = fault_record_trigger_n_o ? 5'h00 : low_q + 5'h01;
	always_ff @(posedge ref_clk_i or negedge rstn_i)
		if (!rstn_i)
			low_q <= 5'h00;
		else
			low_q <= low_d;
	safe_trig_a:
		assert property (outputs_safe_o |-> fault_record_trigger_n_o)
		else $error("dump request low while safe");
	dump_len_a:
		assert property ($rose(fault_record_trigger_n_o) |-> low_q == 5'h0d)
		else $error("dump request length wrong");
	dump_cause_a:
		assert property ($fell(fault_record_trigger_n_o) |-> !outputs_safe_o
			&& ($past(trigger_monitor_a_i, 4) != 2'h3
			|| $past(trigger_monitor_b_i, 4) != 2'h3))
		else $error("dump without monitor fault");
	line_copy_a:
		assert property (!fault_record_trigger_n_o
			&& !$past(fault_record_trigger_n_o)
			|-> lines == $past(dump_status_i))
		else $error("status lines not shifted");
	empty_ready_a:
		assert property (flag_ack_i && flag_data_i == 8'hff |=> page_ready_o)
		else $error("empty page not taken");
	used_next_a:
		assert property (flag_ack_i && flag_data_i == 8'hc3
			&& flag_page_o < 8'hf9
			|=> flag_req_o && flag_page_o == $past(flag_page_o) + 8'h01)
		else $error("used page not skipped");
	erase_zero_a:
		assert property (!log_erase_notice_n_i [*3]
			|=> flag_page_o == 8'h00 && !log_memory_full_o)
		else $error("erase did not restart");
	full_at_a:
		assert property ($rose(log_memory_full_o)
			|-> $past(flag_page_o) == 8'hf9)
		else $error("full at wrong page");
endmodule

bind flt_logger flt_logger_chk flt_logger_chk_i (.ref_clk_i, .rstn_i,
	.trigger_monitor_a_i, .trigger_monitor_b_i, .dump_status_i,
	.log_erase_notice_n_i, .flag_ack_i, .flag_data_i, .outputs_safe_o,
	.fault_record_trigger_n_o, .status_line_0_o, .status_line_1_o,
	.status_line_2_o, .flag_req_o, .flag_page_o, .page_ready_o,
	.log_memory_full_o);

// ===== testbench/flt_flash_model.sv
`timescale 1ns/1ps
// ------------
// flash flag responder
// ------------
module flt_flash_model
(
	input  wire logic       ref_clk_i,
	input  wire logic       req_i,
	input  wire logic [7:0] page_i,
	input  wire logic [7:0] used_i,
	input  wire logic [1:0] lag_i,
	output logic            ack_o,
	output logic [7:0]      data_o
);
	logic [7:0] flag;
	assign flag = (page_i < used_i) ? 8'hc3 : 8'hff;
	// data inverted outside the ack so a late sample is caught
	initial
	begin
		ack_o = 1'b0;
		data_o = 8'h5a;
		forever
		begin
			@(posedge ref_clk_i);
			if (req_i)
			begin
				repeat (lag_i) @(posedge ref_clk_i);
				ack_o <= 1'b1;
				data_o <= flag;
				@(posedge ref_clk_i);
				ack_o <= 1'b0;
				data_o <= ~flag;
			end
		end
	end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
// ------------
// logger bench
// ------------
module tb_top;
	logic       ref_clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic [1:0] mon_a = 2'h3;
	logic [1:0] mon_b = 2'h3;
	logic       sup_ok = 1'b0;
	logic [2:0] dstat = 3'h0;
	logic       erase_n = 1'b1;
	logic       done = 1'b0;
	logic       en = 1'b1;
	logic [7:0] used = 8'h03;
	logic [1:0] lag = 2'h2;
	logic       ack, safe, trig_n, req, ready, full;
	logic [7:0] fdata, page, offs;
	int         num_errors = 0;
	int         samples_checked = 0;
	int         n;
	always #5 ref_clk_i = ~ref_clk_i;
	always @(negedge ref_clk_i) dstat <= dstat + 3'h1;
	flt_logger flt_logger_i (.ref_clk_i, .rstn_i, .clk_en_i(en),
		.trigger_monitor_a_i(mon_a), .trigger_monitor_b_i(mon_b),
		.supplies_ok_i(sup_ok), .dump_status_i(dstat),
		.log_erase_notice_n_i(erase_n), .record_done_i(done),
		.flag_ack_i(ack), .flag_data_i(fdata), .outputs_safe_o(safe),
		.fault_record_trigger_n_o(trig_n), .status_line_0_o(),
		.status_line_1_o(), .status_line_2_o(), .flag_req_o(req),
		.flag_page_o(page), .flag_offset_o(offs),
		.page_ready_o(ready), .log_memory_full_o(full));
	flt_flash_model flt_flash_model_i (.ref_clk_i, .req_i(req),
		.page_i(page), .used_i(used), .lag_i(lag), .ack_o(ack),
		.data_o(fdata));
	task automatic chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk_i);
	endtask
	task automatic pulse_done;
		done = 1'b1;
		cyc(1);
		done = 1'b0;
	endtask
	// 0 ready, 1 dump request, 2 full; a hang ends the run
	task automatic wait_lvl(input int w, input logic lvl);
		n = 0;
		while ((w == 0 ? ready : w == 1 ? trig_n : full) !== lvl)
		begin
			cyc(1);
			n++;
			if (n > 4000)
			begin
				num_errors++;
				give_verdict();
			end
		end
	endtask
	task automatic do_reset;
		rstn_i = 1'b0;
		cyc(5);
		rstn_i = 1'b1;
	endtask
	initial
	begin
		do_reset();
		chk("safe", 8'h01, {7'h0, safe & trig_n});
		wait_lvl(0, 1'b1);
		chk("page", 8'h03, page);
		chk("offset", 8'h00, offs);
		cyc(20);
		chk("no supply", 8'h01, {7'h0, safe & trig_n});
		sup_ok = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			cyc(20);
			chk("healthy", 8'h01, {7'h0, trig_n});
			mon_a = (i < 3) ? 2'(i) : 2'h3;
			mon_b = (i < 3) ? 2'h3 : 2'h1;
			wait_lvl(1, 1'b0);
			wait_lvl(1, 1'b1);
			chk("dump len", 8'h0d, n[7:0]);
			cyc(10);
			chk("once", 8'h01, {7'h0, trig_n});
			mon_a = 2'h0;
			mon_b = 2'h0;
			cyc(5);
			mon_a = 2'h3;
			mon_b = 2'h3;
		end
		pulse_done();
		cyc(2);
		chk("next page", 8'h04, page);
		en = 1'b0;
		pulse_done();
		cyc(2);
		chk("frozen", 8'h04, page);
		en = 1'b1;
		erase_n = 1'b0;
		cyc(3);
		erase_n = 1'b1;
		cyc(3);
		chk("erased", 8'h00, page);
		for (int i = 0; i < 250; i++)
		begin
			chk("not full", 8'h00, {7'h0, full});
			pulse_done();
			cyc(1);
		end
		cyc(2);
		chk("full", 8'h01, {7'h0, full});
		chk("no ready", 8'h00, {7'h0, ready});
		used = 8'hfa;
		lag = 2'h0;
		do_reset();
		wait_lvl(2, 1'b1);
		chk("scan full", 8'h00, {7'h0, ready});
		give_verdict();
	end
endmodule
